// >>> core/sram_pkg.sv
/*
 * Shared constants and types for the synchronous burst SRAM control block.
 * Assumes a single clock domain and that every user of the write buffer
 * agrees on the command layout declared here.
 */
package sram_pkg;

	// ****************************************************************
	// Array geometry
	// ****************************************************************
	localparam int ADDR_W     = 17;
	localparam int DATA_W     = 36;
	localparam int LANES      = 4;
	localparam int BYTE_W     = 8;
	localparam int PARITY_LSB = 32;
	localparam int BURST_W    = 2;
	localparam int FIFO_DEPTH = 16;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [BURST_W-1:0] CNT_RESET   = 2'h0;
	localparam logic [BURST_W-1:0] START_RESET = 2'h0;
	localparam logic [DATA_W-1:0]  DATA_RESET  = 36'h0;

	// ****************************************************************
	// Cycle types remembered between edges
	// ****************************************************************
	typedef enum logic [1:0] {
		CYC_IDLE  = 2'b00,
		CYC_READ  = 2'b01,
		CYC_WRITE = 2'b10
	} cyc_t;

	// One buffered write: target word, data and enabled lanes.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0]  lane_en;
	} wr_cmd_t;

	localparam int CMD_W = ADDR_W + DATA_W + LANES;

endpackage

// >>> core/sync_sram_burst_cycle_control.sv
/*
 * Cycle decoder, burst counter, byte-lane writes and bus drive control of a
 * zero-turnaround synchronous SRAM, with a write buffer in front of the array.
 * Assumes the memory controller runs on the same clock and presents address,
 * control and write data set up to the rising edge; the data pins are split
 * into input, output and output enable and resolved outside.
 */
// Operation
// - Enabled, selected edge with load low starts read or write per direction pin.
// - Advance high after load or burst steps counter, keeps operation type.
// - Direction pin is ignored while advancing; burst keeps its loaded direction.
// - Any select inactive with load low starts a deselect, ending the burst.
// - Data bus floats one cycle after deselect, after pending transfer finishes.
// - Clock gate high makes the edge absent; no synchronous input acts.
// - Suspended edge holds the cycle, burst, read and write-capture registers and the data pins; the write buffer still drains.
// - Selected only when both low-active selects low and high-active select high.
// - Any one select at its inactive level means deselected.
// - Data outputs float throughout power-up.
// - Each low-active lane select writes one byte plus its parity bit.
// - Any combination of lanes may be written in one cycle.
// - Burst order high gives low bits as start XOR counter.
// - Burst order low gives low bits as start plus counter modulo four.
// - After the fourth address the counter wraps and keeps counting.
// - Read data for edge n appears during cycle n+1.
// - Write data is captured into a register on the rising edge.
// - Output disable high floats the data pins at once.
`timescale 1ns/1ps

// ****************************************************************
// Write buffer
// ****************************************************************
module sram_wr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [PTR_W:0]   count_reg;
	logic             push, pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = store[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage carries no reset; only the pointers and the count define what is valid.
	always_ff @(posedge clock) begin
		if (push) begin
			store[wr_ptr_reg] <= in_data;
		end
	end
	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end
endmodule

// ****************************************************************
// Device top
// ****************************************************************
module sync_sram_burst_cycle_control #(
	parameter int FIFO_DEPTH = sram_pkg::FIFO_DEPTH
) (
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	input  wire logic                        clock_gate_n,
	input  wire logic [sram_pkg::ADDR_W-1:0] addr,
	input  wire logic                        read_not_write,
	input  wire logic                        advance_or_load,
	input  wire logic                        chip_sel_a_n,
	input  wire logic                        chip_sel_c_n,
	input  wire logic                        chip_sel_b,
	input  wire logic                        byte_lane1_write_n,
	input  wire logic                        byte_lane2_write_n,
	input  wire logic                        byte_lane3_write_n,
	input  wire logic                        byte_lane4_write_n,
	input  wire logic                        burst_order_sel,
	input  wire logic                        out_disable,
	input  wire logic [sram_pkg::DATA_W-1:0] data_in,
	output logic      [sram_pkg::DATA_W-1:0] data_out,
	output logic                             data_oe,
	output logic                             write_buf_ready,
	input  wire logic                        array_stall
);
	import sram_pkg::*;

	logic [DATA_W-1:0]     mem [2**ADDR_W];
	logic                  en, sel, drive_reg, wr_pend_reg;
	logic                  buf_ready_reg, fifo_in_ready, fifo_out_valid, push;
	logic [LANES-1:0]      lane_en, wr_lane_reg;
	cyc_t                  cyc_reg, cyc_next;
	logic [BURST_W-1:0]    cnt_reg, cnt_next, start_reg, start_next, low_next;
	logic [ADDR_W-3:0]     base_reg, base_next;
	logic [ADDR_W-1:0]     op_addr, wr_addr_reg;
	logic [DATA_W-1:0]     rd_data_reg;
	wr_cmd_t               push_cmd, drain_cmd;
	logic [CMD_W-1:0]      drain_bits;

	// Each lane covers one byte and its own parity bit.
	function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] lanes);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < LANES; i++) begin
			m[i*BYTE_W +: BYTE_W] = {BYTE_W{lanes[i]}};
			m[PARITY_LSB + i]     = lanes[i];
		end
		return m;
	endfunction

	// ****************************************************************
	// Input decode
	// ****************************************************************
	// A gated edge is treated as if it never came.
	assign en      = ~clock_gate_n;
	// All three selects must be at their active level at once.
	assign sel     = ~chip_sel_a_n & ~chip_sel_c_n & chip_sel_b;
	assign lane_en = ~{byte_lane4_write_n, byte_lane3_write_n,
		byte_lane2_write_n, byte_lane1_write_n};

	// ****************************************************************
	// Cycle decode and burst counter
	// ****************************************************************
	// Next cycle type, counter and address as this edge would set them.
	always_comb begin
		cyc_next   = cyc_reg;
		cnt_next   = cnt_reg;
		start_next = start_reg;
		base_next  = base_reg;
		if (!advance_or_load) begin
			if (sel) begin
				cyc_next   = read_not_write ? CYC_READ : CYC_WRITE;
				cnt_next   = CNT_RESET;
				start_next = addr[BURST_W-1:0];
				base_next  = addr[ADDR_W-1:BURST_W];
			end else begin
				cyc_next = CYC_IDLE;
			end
		end else begin
			unique case (cyc_reg)
				// Direction pin is not looked at; the type stays as loaded.
				CYC_READ,
				CYC_WRITE: cnt_next = cnt_reg + 2'h1;
				CYC_IDLE:  cyc_next = CYC_IDLE;
				default:   cyc_next = CYC_IDLE;
			endcase
		end
	end

	// Only the two low bits move; the upper part is the loaded base.
	assign low_next = burst_order_sel ? (start_next ^ cnt_next)
		: (start_next + cnt_next);
	assign op_addr  = {base_next, low_next};

	// Burst state advances only on edges that are not gated.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cyc_reg   <= CYC_IDLE;
			cnt_reg   <= CNT_RESET;
			start_reg <= START_RESET;
			base_reg  <= '0;
		end else if (en) begin
			cyc_reg   <= cyc_next;
			cnt_reg   <= cnt_next;
			start_reg <= start_next;
			base_reg  <= base_next;
		end
	end

	// ****************************************************************
	// Read path and bus drive
	// ****************************************************************
	// Read data is taken at the edge and shown for the whole next cycle.
	// A read of a word still waiting in the write buffer returns the old
	// contents; the controller must not rely on read-after-write forwarding.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_reg <= DATA_RESET;
			drive_reg   <= 1'b0;
		end else if (en) begin
			drive_reg <= (cyc_next == CYC_READ);
			if (cyc_next == CYC_READ) begin
				rd_data_reg <= mem[op_addr];
			end
		end
	end

	assign data_out = rd_data_reg;
	// Output disable acts without the clock, so it bypasses the drive flop.
	assign data_oe  = drive_reg & ~out_disable;

	// ****************************************************************
	// Write path
	// ****************************************************************
	// Address and lanes belong to the edge; their data comes one edge later.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_lane_reg <= '0;
		end else if (en) begin
			wr_pend_reg <= (cyc_next == CYC_WRITE);
			wr_addr_reg <= op_addr;
			wr_lane_reg <= lane_en;
		end
	end

	// The buffer entry is the data input register; a write with no lane
	// selected stores nothing at all.
	assign push = en & wr_pend_reg & (|wr_lane_reg);
	assign push_cmd = '{addr: wr_addr_reg, data: data_in, lane_en: wr_lane_reg};
	assign drain_cmd = wr_cmd_t'(drain_bits);

	sram_wr_fifo #(
		.WIDTH (CMD_W),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clock     (clock),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_cmd),
		.out_valid (fifo_out_valid),
		.out_ready (~array_stall),
		.out_data  (drain_bits)
	);

	// Ready is registered, so it lags the buffer by one edge.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			buf_ready_reg <= 1'b1;
		end else begin
			buf_ready_reg <= fifo_in_ready;
		end
	end

	assign write_buf_ready = buf_ready_reg;

	// Merge only the enabled lanes into the stored word.
	always_ff @(posedge clock) begin
		if (fifo_out_valid && !array_stall) begin
			mem[drain_cmd.addr] <= (mem[drain_cmd.addr] & ~lane_mask(drain_cmd.lane_en))
				| (drain_cmd.data & lane_mask(drain_cmd.lane_en));
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence s_load_read;
		en && sel && !advance_or_load && read_not_write;
	endsequence
	sequence s_load_write;
		en && sel && !advance_or_load && !read_not_write;
	endsequence
	sequence s_advance;
		en && advance_or_load && (cyc_reg != CYC_IDLE);
	endsequence

	property p_load_read;
		s_load_read |=> (cyc_reg == CYC_READ) && drive_reg && (cnt_reg == 2'h0);
	endproperty
	a_load_read: assert property (p_load_read) else $error("load read not started");
	property p_load_write;
		s_load_write ##1 (en && |wr_lane_reg && fifo_in_ready) |-> push && !drive_reg;
	endproperty
	a_load_write: assert property (p_load_write) else $error("write data not taken");
	property p_burst_step;
		s_advance |=> (cnt_reg == $past(cnt_reg) + 2'h1) && (cyc_reg == $past(cyc_reg));
	endproperty
	a_burst_step: assert property (p_burst_step) else $error("burst did not step");
	property p_burst_upper;
		s_advance |=> (base_reg == $past(base_reg)) && (start_reg == $past(start_reg));
	endproperty
	a_burst_upper: assert property (p_burst_upper) else $error("upper bits moved");
	property p_wrap;
		s_advance ##1 s_advance ##1 s_advance ##1 s_advance |=> cnt_reg == $past(cnt_reg, 4);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");
	property p_deselect;
		en && !advance_or_load && !sel |=> (cyc_reg == CYC_IDLE) && !data_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect left bus driven");
	property p_noop;
		en && advance_or_load && (cyc_reg == CYC_IDLE) |=> !drive_reg && !wr_pend_reg;
	endproperty
	a_noop: assert property (p_noop) else $error("noop performed an access");
	property p_suspend;
		!en |=> $stable(cyc_reg) && $stable(cnt_reg) && $stable(rd_data_reg)
			&& $stable(drive_reg) && $stable(wr_addr_reg);
	endproperty
	a_suspend: assert property (p_suspend) else $error("state changed on gated edge");
	property p_order_lin;
		(s_advance and !burst_order_sel) ##1 (cyc_reg == CYC_READ) |->
			rd_data_reg == $past(mem[op_addr]);
	endproperty
	a_order_lin: assert property (p_order_lin) else $error("read data mismatch");
	property p_out_disable;
		out_disable |-> !data_oe;
	endproperty
	a_out_disable: assert property (p_out_disable) else $error("pins driven while disabled");
	property p_lane_none;
		en && wr_pend_reg && (wr_lane_reg == 4'h0) |-> !push;
	endproperty
	a_lane_none: assert property (p_lane_none) else $error("empty write was buffered");
endmodule

// >>> tb/sram_host_model.sv
/*
 * Memory controller model that drives the SRAM pins one cycle at a time.
 * Assumes the bench calls cyc just after each rising edge of the clock.
 */
`timescale 1ns/1ps

module sram_host_model (
	output logic				clock_gate_n,
	output logic [sram_pkg::ADDR_W-1:0]	addr,
	output logic				read_not_write,
	output logic				advance_or_load,
	output logic				chip_sel_a_n,
	output logic				chip_sel_c_n,
	output logic				chip_sel_b,
	output logic [3:0]			lanes_n,
	output logic [sram_pkg::DATA_W-1:0]	data_in
);
	import sram_pkg::*;

	logic [DATA_W-1:0]	nxt;

	// Start deselected and running, so nothing is loaded before the first call.
	initial begin
		{clock_gate_n, read_not_write, advance_or_load} = 3'h0;
		{chip_sel_a_n, chip_sel_c_n, chip_sel_b} = 3'h6;
		addr = '0;
		lanes_n = 4'hf;
		data_in = '0;
		nxt = '0;
	end

	// One request, launched after an edge and held until the next edge samples it.
	task automatic cyc(input logic g, adv, rw, input logic [2:0] s,
		input logic [ADDR_W-1:0] a, input logic [3:0] ln,
		input logic [DATA_W-1:0] wd, input logic wr);
		clock_gate_n <= g;
		advance_or_load <= adv;
		read_not_write <= rw;
		{chip_sel_a_n, chip_sel_c_n, chip_sel_b} <= s;
		addr <= a;
		lanes_n <= ln;
		data_in <= nxt;
		// Data trails its address; an idle bus toggles so a stale word never looks valid.
		if (!g)
			nxt = wr ? wd : ~nxt;
	endtask
endmodule

// >>> tb/sync_sram_burst_cycle_control_tb_top.sv
/*
 * Self-checking bench for the burst SRAM control block.
 * Assumes sram_pkg and the host model; expectations are queued per cycle.
 */
`timescale 1ns/1ps

module sync_sram_burst_cycle_control_tb_top;
	import sram_pkg::*;

	typedef struct {
		int			due;
		logic			oe;
		logic [DATA_W-1:0]	d;
	} note_t;

	logic		clock, rst_b, burst_order_sel, out_disable, array_stall, en_seen;
	logic		clock_gate_n, read_not_write, advance_or_load, prev_oe;
	logic		chip_sel_a_n, chip_sel_c_n, chip_sel_b, data_oe, write_buf_ready;
	logic [3:0]	lanes_n;
	logic [ADDR_W-1:0]	addr, base;
	logic [DATA_W-1:0]	data_in, data_out, prev_d;
	logic [DATA_W-1:0]	mem[int];
	logic [1:0]	k;
	int		failures, n_tests, cnt, seed, act;
	note_t		q[$];
	logic [3:0]	lane_set[7] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf, 4'ha};
	localparam logic [ADDR_W-1:0] word_a = 17'h0a5c0, word_b = 17'h0a5c8, word_c = 17'h1f000;

	sync_sram_burst_cycle_control sync_sram_burst_cycle_control_inst (
		.clock, .rst_b, .clock_gate_n, .addr, .read_not_write, .advance_or_load,
		.chip_sel_a_n, .chip_sel_c_n, .chip_sel_b, .byte_lane1_write_n(lanes_n[0]),
		.byte_lane2_write_n(lanes_n[1]), .byte_lane3_write_n(lanes_n[2]),
		.byte_lane4_write_n(lanes_n[3]), .burst_order_sel, .out_disable, .data_in,
		.data_out, .data_oe, .write_buf_ready, .array_stall);

	sram_host_model sram_host_model_inst (.clock_gate_n, .addr, .read_not_write,
		.advance_or_load, .chip_sel_a_n, .chip_sel_c_n, .chip_sel_b, .lanes_n, .data_in);

	// Free-running 10 MHz clock.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input string nm, input logic [DATA_W-1:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	function automatic logic [DATA_W-1:0] rnd();
		return DATA_W'({$random(seed), $random(seed)});
	endfunction

	// One cycle: model the cycle type and burst address, note what the pins show next.
	task automatic step(input logic g, adv, rw, input logic [2:0] s,
		input logic [ADDR_W-1:0] a, input logic [3:0] ln, input logic [DATA_W-1:0] wd);
		logic [ADDR_W-1:0]	cur;
		logic [DATA_W-1:0]	m;
		@(posedge clock);
		if (!g) begin
			if (!adv) begin
				act = (s != 3'h1) ? 0 : (rw ? 1 : 2);
				base = a;
				k = 2'h0;
			end else if (act != 0)
				k = k + 2'h1;
			cur = {base[ADDR_W-1:2], burst_order_sel ? base[1:0] ^ k : base[1:0] + k};
			m = '0;
			for (int i = 0; i < LANES; i++)
				if (!ln[i])
					m = m | (DATA_W'(8'hff) << (BYTE_W * i)) | (DATA_W'(1) << (PARITY_LSB + i));
			if (act == 2)
				mem[cur] = ((mem.exists(cur) ? mem[cur] : '0) & ~m) | (wd & m);
			q.push_back('{cnt + 2, act == 1, mem.exists(cur) ? mem[cur] : '0});
		end
		sram_host_model_inst.cyc(g, adv, rw, s, a, ln, wd, act == 2);
	endtask

	// Deselect cycles keep the bus quiet while the write buffer drains.
	task automatic idle(input int n);
		repeat (n) step(1'b0, 1'b0, 1'b1, 3'h6, '0, 4'hf, '0);
	endtask

	// A note falls due the cycle after its edge; a suspended edge must leave the pins alone.
	always @(posedge clock)
		en_seen <= !clock_gate_n;
	always @(negedge clock) begin
		cnt++;
		if (rst_b === 1'b1 && en_seen === 1'b0) begin
			check("held_oe", data_oe, prev_oe);
			check("held_data", data_out, prev_d);
		end else if (q.size() > 0 && q[0].due == cnt) begin
			check("drive", data_oe, q[0].oe);
			if (q[0].oe)
				check("read_data", data_out, q[0].d);
			void'(q.pop_front());
		end
		prev_oe = data_oe;
		prev_d = data_out;
	end

	// The run is about 160 cycles; a hang is cut off well past that.
	initial begin
		#(100 * 2000);
		failures++;
		complete_run;
	end

	// Main sequence: writes, burst reads in both orders, deselects, suspend, buffer fill.
	initial begin
		seed = 32'h3b9d96e2;
		{rst_b, burst_order_sel, out_disable, array_stall} = 4'h0;
		{failures, n_tests, cnt, act} = '0;
		k = 2'h0;
		base = '0;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(negedge clock);
		check("oe_reset", data_oe, 1'b0);
		check("ready_reset", write_buf_ready, 1'b1);
		for (int i = 0; i < 4; i++)
			step(1'b0, i > 0, i > 0 ? 1'($random(seed)) : 1'b0, 3'h1, word_a + 2, 4'h0, rnd());
		for (int i = 0; i < 7; i++)
			step(1'b0, 1'b0, 1'b0, 3'h1, word_b, lane_set[i], rnd());
		idle(20);
		for (int o = 0; o < 2; o++) begin
			burst_order_sel <= o[0];
			idle(1);
			for (int s = 0; s < 4; s++)
				for (int i = 0; i < 6; i++)
					step(1'b0, i > 0, i > 0 ? 1'($random(seed)) : 1'b1, 3'h1,
						word_a | ADDR_W'(s), 4'hf, rnd());
			step(1'b0, 1'b0, 1'b1, 3'h1, word_b, 4'hf, rnd());
		end
		for (int i = 0; i < 3; i++) begin
			step(1'b0, 1'b0, 1'b1, 3'h1, word_b, 4'hf, rnd());
			step(1'b0, 1'b0, 1'b1, 3'h1 ^ 3'(1 << i), word_a, 4'hf, rnd());
			step(1'b0, 1'b1, 1'b1, 3'h1, word_a, 4'hf, rnd());
			step(1'b0, 1'b1, 1'b0, 3'h1, word_a, 4'hf, rnd());
		end
		step(1'b0, 1'b0, 1'b1, 3'h1, word_a + 1, 4'hf, rnd());
		repeat (3)
			step(1'b1, 1'($random(seed)), 1'($random(seed)), 3'($random(seed)),
				ADDR_W'($random(seed)), 4'($random(seed)), rnd());
		// Raised after the held-pin check and kept across one gated edge.
		#60 out_disable = 1'b1;
		#10 check("oe_forced_off", data_oe, 1'b0);
		#70 out_disable = 1'b0;
		step(1'b0, 1'b1, 1'b0, 3'h1, word_a, 4'hf, rnd());
		array_stall <= 1'b1;
		for (int i = 0; i < 24; i++)
			step(1'b0, i > 0, 1'b0, 3'h1, word_c, 4'h0, rnd());
		idle(2);
		@(negedge clock);
		check("buffer_full", write_buf_ready, 1'b0);
		array_stall <= 1'b0;
		idle(24);
		@(negedge clock);
		check("buffer_drained", write_buf_ready, 1'b1);
		// The last note falls due a negedge later; let the watcher take it first.
		repeat (2) @(posedge clock);
		check("notes_left", q.size() == 0, 1'b1);
		complete_run;
	end
endmodule
